// File: hw/spfs_end_pulse.sv
// active-low transfer end output one cycle after the last write
`timescale 1ns/1ns
module spfs_end_pulse
  import spfs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic last_write, // last write cycle of the transfer
  output logic end_n // transfer end, active low
);
  // low in the cycle after the last write strobe is seen
  always_ff @(posedge clk) begin
    if (rst) begin
      end_n <= 1'b1;
    end else begin
      end_n <= !last_write;
    end
  end

  a_end_follows: assert property (@(posedge clk) disable iff (rst)
    last_write |=> !end_n)
    else $error("transfer end missing");
  a_end_only: assert property (@(posedge clk) disable iff (rst)
    !last_write |=> end_n)
    else $error("stray transfer end");
endmodule : spfs_end_pulse

// File: hw/spfs_req_sense.sv
// active-low dma request detector with edge or level sense
`timescale 1ns/1ns
module spfs_req_sense
  import spfs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic req_n, // request pin level, active low
  input wire logic enable, // function selected and allowed
  input wire spfs_pkg::spfs_sense_t mode, // edge or level
  output logic req // request to the dma unit
);
  logic prev_n; // last sampled pin level
  logic next_req; // request before registering

  // remember previous level for falling edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_n <= 1'b1;
    end else begin
      prev_n <= req_n;
    end
  end

  // level: low means request; edge: high-to-low once
  always_comb begin
    if (!enable) begin
      next_req = 1'b0;
    end else if (mode == SPFS_SENSE_EDGE) begin
      next_req = prev_n && !req_n;
    end else begin
      next_req = !req_n;
    end
  end

  // registered request
  always_ff @(posedge clk) begin
    if (rst) begin
      req <= 1'b0;
    end else begin
      req <= next_req;
    end
  end

  a_edge_single: assert property (@(posedge clk) disable iff (rst)
    (enable && mode == SPFS_SENSE_EDGE && prev_n && !req_n) |=> req)
    else $error("edge request not seen");
  a_disabled_quiet: assert property (@(posedge clk) disable iff (rst)
    !$past(enable) |-> !req)
    else $error("request passed while deselected");
endmodule : spfs_req_sense

// File: hw/spfs_top.sv
// shared pin function select for four multiplexed package pins
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
module spfs_top
  import spfs_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET,
  // register port
  input wire logic [1:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // internal function sources
  input wire logic UPPER_ADDRESS_LINE, // address bit 18 from the bus unit
  input wire logic TIMER1_PULSE, // reload timer channel 1 pulse
  input wire logic SER0_CLK_OUT, // serial 0 generated clock
  input wire logic SER1_CLK_OUT, // serial 1 generated clock
  input wire logic DMA0_LAST_WRITE, // last write of channel 0
  input wire logic DMA1_LAST_WRITE, // last write of channel 1
  // pin A: upper address / timer wave
  output logic PIN_ADDR_TIMER,
  // pin B: serial0 clock / dma0 request (two-way)
  input wire logic PIN_CK0_DREQ_IN,
  output logic PIN_CK0_DREQ_OUT,
  output logic PIN_CK0_DREQ_OE,
  // pin C: serial1 clock / dma0 transfer end (two-way)
  input wire logic PIN_CK1_TEND_IN,
  output logic PIN_CK1_TEND_OUT,
  output logic PIN_CK1_TEND_OE,
  // pin D: clocked serial rx / serial1 clear to send
  input wire logic PIN_RX_CTS,
  // dedicated dma1 pins
  input wire logic DMA1_REQUEST_N,
  output logic DMA1_TRANSFER_END_N,
  // routed to internal functions
  output logic SER0_CLK_IN,
  output logic SER1_CLK_IN,
  output logic DMA0_REQ,
  output logic DMA1_REQ,
  output logic CLOCKED_SERIAL_RX,
  output logic SERIAL1_CLEAR_TO_SEND_N
);
  logic [7:0] timer_control_reg; // timer output control copy
  logic [7:0] dma_mode_reg; // dma mode copy
  logic [7:0] serial1_reg; // serial1 clock disable and cts enable
  logic sel_timer; // pin A carries timer wave
  logic sel_dma0_request; // pin B is dma0 request
  logic sel_dma0_transfer_end; // pin C is dma0 transfer end
  logic sel_serial1_clear_to_send; // pin D is clear to send
  logic dma0_end_n; // transfer end channel 0
  logic dma1_end_n; // transfer end channel 1
  logic dma0_req; // detected channel 0 request
  logic dma1_req; // detected channel 1 request
  spfs_sense_t sense0; // channel 0 sense mode
  spfs_sense_t sense1; // channel 1 sense mode

  // control register writes
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      timer_control_reg <= SPFS_RST_REG;
      dma_mode_reg <= SPFS_RST_REG;
      serial1_reg <= SPFS_RST_REG;
    end else if (REG_WR) begin
      case (REG_ADDR)
        SPFS_OFF_TIMER: timer_control_reg <= REG_WDATA;
        SPFS_OFF_DMA: dma_mode_reg <= REG_WDATA;
        SPFS_OFF_SER1: serial1_reg <= REG_WDATA;
        default: ; // status is read only
      endcase
    end
  end

  // selection decode from the control bits
  assign sel_timer = timer_control_reg[SPFS_B_TOC_HI] | timer_control_reg[SPFS_B_TOC_LO];
  assign sel_dma0_request = dma_mode_reg[SPFS_B_DST_HI] | dma_mode_reg[SPFS_B_SRC_HI];
  assign sel_dma0_transfer_end = serial1_reg[SPFS_B_CK1_DIS];
  assign sel_serial1_clear_to_send = serial1_reg[SPFS_B_CTS_EN];
  assign sense0 = dma_mode_reg[SPFS_B_SENSE0] ? SPFS_SENSE_EDGE : SPFS_SENSE_LEVEL;
  assign sense1 = dma_mode_reg[SPFS_B_SENSE1] ? SPFS_SENSE_EDGE : SPFS_SENSE_LEVEL;

  // register read, data one cycle after the strobe
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        SPFS_OFF_TIMER: REG_RDATA <= timer_control_reg;
        SPFS_OFF_DMA: REG_RDATA <= dma_mode_reg;
        SPFS_OFF_SER1: REG_RDATA <= serial1_reg;
        SPFS_OFF_STAT: REG_RDATA <= {4'h0, sel_serial1_clear_to_send, sel_dma0_transfer_end, sel_dma0_request, sel_timer};
        default: REG_RDATA <= 8'h00;
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  // dma0 request: only when selected and not memory-to-memory
  spfs_req_sense u_req0 (
    .clk(MCLK),
    .rst(RESET),
    .req_n(PIN_CK0_DREQ_IN),
    .enable(sel_dma0_request && !dma_mode_reg[SPFS_B_MEM2MEM]),
    .mode(sense0),
    .req(dma0_req)
  );

  // dma1 request on its dedicated pin
  spfs_req_sense u_req1 (
    .clk(MCLK),
    .rst(RESET),
    .req_n(DMA1_REQUEST_N),
    .enable(1'b1),
    .mode(sense1),
    .req(dma1_req)
  );

  // transfer end generators
  spfs_end_pulse u_end0 (
    .clk(MCLK),
    .rst(RESET),
    .last_write(DMA0_LAST_WRITE),
    .end_n(dma0_end_n)
  );
  spfs_end_pulse u_end1 (
    .clk(MCLK),
    .rst(RESET),
    .last_write(DMA1_LAST_WRITE),
    .end_n(dma1_end_n)
  );

  // pin A output mux
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      PIN_ADDR_TIMER <= 1'b0;
    end else begin
      PIN_ADDR_TIMER <= sel_timer ? TIMER1_PULSE : UPPER_ADDRESS_LINE;
    end
  end

  // pin B: clock out when enabled, input otherwise, released for dma request
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      PIN_CK0_DREQ_OUT <= 1'b0;
      PIN_CK0_DREQ_OE <= 1'b0;
      SER0_CLK_IN <= 1'b0;
    end else begin
      PIN_CK0_DREQ_OUT <= SER0_CLK_OUT;
      PIN_CK0_DREQ_OE <= !sel_dma0_request && serial1_reg[SPFS_B_CK0_OUT];
      SER0_CLK_IN <= sel_dma0_request ? 1'b0 : PIN_CK0_DREQ_IN;
    end
  end

  // pin C: transfer end output or serial1 clock in/out
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      PIN_CK1_TEND_OUT <= 1'b0;
      PIN_CK1_TEND_OE <= 1'b0;
      SER1_CLK_IN <= 1'b0;
    end else begin
      PIN_CK1_TEND_OUT <= sel_dma0_transfer_end ? dma0_end_n : SER1_CLK_OUT;
      PIN_CK1_TEND_OE <= sel_dma0_transfer_end || serial1_reg[SPFS_B_CK1_OUT];
      SER1_CLK_IN <= sel_dma0_transfer_end ? 1'b0 : PIN_CK1_TEND_IN;
    end
  end

  // pin D and dedicated pins
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      CLOCKED_SERIAL_RX <= 1'b1;
      SERIAL1_CLEAR_TO_SEND_N <= 1'b1;
      DMA1_TRANSFER_END_N <= 1'b1;
      DMA0_REQ <= 1'b0;
      DMA1_REQ <= 1'b0;
    end else begin
      CLOCKED_SERIAL_RX <= sel_serial1_clear_to_send ? 1'b1 : PIN_RX_CTS;
      SERIAL1_CLEAR_TO_SEND_N <= sel_serial1_clear_to_send ? PIN_RX_CTS : 1'b1;
      DMA1_TRANSFER_END_N <= dma1_end_n;
      DMA0_REQ <= dma0_req;
      DMA1_REQ <= dma1_req;
    end
  end

  a_timer_select: assert property (@(posedge MCLK) disable iff (RESET)
    sel_timer |=> PIN_ADDR_TIMER == $past(TIMER1_PULSE))
    else $error("timer wave not on pin");
  a_addr_select: assert property (@(posedge MCLK) disable iff (RESET)
    !sel_timer |=> PIN_ADDR_TIMER == $past(UPPER_ADDRESS_LINE))
    else $error("address line not on pin");
  a_dreq_release: assert property (@(posedge MCLK) disable iff (RESET)
    sel_dma0_request |=> !PIN_CK0_DREQ_OE && !SER0_CLK_IN)
    else $error("dma0 request pin driven");
  a_dma0_transfer_end_pin: assert property (@(posedge MCLK) disable iff (RESET)
    (sel_dma0_transfer_end && DMA0_LAST_WRITE) |=> ##1 (PIN_CK1_TEND_OE && !PIN_CK1_TEND_OUT))
    else $error("transfer end not on shared pin");
  a_cts_route: assert property (@(posedge MCLK) disable iff (RESET)
    sel_serial1_clear_to_send |=> CLOCKED_SERIAL_RX)
    else $error("receive not held inactive");
  a_dma1_transfer_end_pin: assert property (@(posedge MCLK) disable iff (RESET)
    DMA1_LAST_WRITE |=> ##1 !DMA1_TRANSFER_END_N)
    else $error("dma1 transfer end missing");
  a_m2m_ignore: assert property (@(posedge MCLK) disable iff (RESET)
    dma_mode_reg[SPFS_B_MEM2MEM] [*2] |=> !DMA0_REQ)
    else $error("request seen in memory copy");
  a_req1_level: assert property (@(posedge MCLK) disable iff (RESET)
    (sense1 == SPFS_SENSE_LEVEL && !DMA1_REQUEST_N) |=> ##1 DMA1_REQ)
    else $error("dma1 level request lost");
endmodule : spfs_top

// File: pkg/spfs_pkg.sv
// constants and types for the shared pin function select block
// Behaviour
// - reset selects upper address line on timer pin
// - either timer control bit selects timer wave
// - dma mode high bits select dma0 request
// - clock disable bit selects dma0 transfer end
// - cts enable selects serial1 clear to send
// - dma0 transfer end low on last write
// - dma1 transfer end low on last write
// - dma0 request active low, ignored memory-to-memory
// - dma1 request active low, edge or level
// - timer pin carries reload timer channel 1 pulse
// - serial clock pins work as input or output
package spfs_pkg;
  // register offsets on the plain register port
  localparam logic [1:0] SPFS_OFF_TIMER = 2'h0; // timer_control_reg copy
  localparam logic [1:0] SPFS_OFF_DMA = 2'h1; // dma_mode_reg copy
  localparam logic [1:0] SPFS_OFF_SER1 = 2'h2; // serial1 control and serial clock direction bits
  localparam logic [1:0] SPFS_OFF_STAT = 2'h3; // read-only pin selection state
  // field positions
  localparam int SPFS_B_TOC_LO = 0; // timer_out_ctl_lo
  localparam int SPFS_B_TOC_HI = 1; // timer_out_ctl_hi
  localparam int SPFS_B_SRC_HI = 0; // src_mode_hi
  localparam int SPFS_B_DST_HI = 1; // dest_mode_hi
  localparam int SPFS_B_MEM2MEM = 2; // channel 0 memory-to-memory mode
  localparam int SPFS_B_SENSE0 = 3; // channel 0 edge sense when set
  localparam int SPFS_B_SENSE1 = 4; // channel 1 edge sense when set
  localparam int SPFS_B_CK1_DIS = 0; // serial1_clock_disable
  localparam int SPFS_B_CTS_EN = 1; // serial1_cts_enable
  localparam int SPFS_B_CK0_OUT = 2; // serial 0 clock is an output
  localparam int SPFS_B_CK1_OUT = 3; // serial 1 clock is an output
  // reset values
  localparam logic [7:0] SPFS_RST_REG = 8'h00;
  // end pulse length in cycles for a transfer end
  localparam int SPFS_END_CYCLES = 1;
  // request detector modes
  typedef enum logic [1:0] {
    SPFS_SENSE_LEVEL = 2'h1,
    SPFS_SENSE_EDGE = 2'h2
  } spfs_sense_t;
endpackage : spfs_pkg

// File: verif/spfs_ext_peer.sv
// external peripheral model for the shared two-way pins and dma1 request
`timescale 1ns/1ns
module spfs_ext_peer (
  input wire logic ck0_oe, // device drives pin b
  input wire logic ck0_out, // device level on pin b
  input wire logic ck1_oe, // device drives pin c
  input wire logic ck1_out, // device level on pin c
  input wire logic ext0, // peer clock or request level for pin b
  input wire logic ext1, // peer clock level for pin c
  input wire logic req1_lvl, // peer dma1 request level
  output logic pin0, // resolved pin b
  output logic pin1, // resolved pin c
  output logic req1_n // dma1 request, low asks for service
);
  // peer drives a pin only while the device has released it
  assign pin0 = ck0_oe ? ck0_out : ext0;
  assign pin1 = ck1_oe ? ck1_out : ext1;
  // request pulled low by the peer to ask for service
  assign req1_n = req1_lvl;
endmodule // spfs_ext_peer

// File: verif/spfs_top_tb.sv
// self-checking bench for the shared pin function select block
`timescale 1ns/1ns
module spfs_top_tb;
  import spfs_pkg::*;
  logic MCLK = 0, RESET = 1, REG_WR = 0, REG_RD = 0; // clock, reset, strobes
  logic [1:0] REG_ADDR = 2'h0; // register offset
  logic [7:0] REG_WDATA = 8'h00, REG_RDATA, t_reg, d_reg, s_reg; // bus data, shadow regs
  logic UPPER_ADDRESS_LINE = 0, TIMER1_PULSE = 0, SER0_CLK_OUT = 0, SER1_CLK_OUT = 0;
  logic DMA0_LAST_WRITE = 0, DMA1_LAST_WRITE = 0, PIN_RX_CTS = 1, ext0 = 1, ext1 = 0, req1 = 1;
  logic PIN_ADDR_TIMER, PIN_CK0_DREQ_IN, PIN_CK0_DREQ_OUT, PIN_CK0_DREQ_OE, PIN_CK1_TEND_IN;
  logic PIN_CK1_TEND_OUT, PIN_CK1_TEND_OE, DMA1_REQUEST_N, DMA1_TRANSFER_END_N, SER0_CLK_IN;
  logic SER1_CLK_IN, DMA0_REQ, DMA1_REQ, CLOCKED_SERIAL_RX, SERIAL1_CLEAR_TO_SEND_N;
  int fail_count = 0, num_checks = 0, c_r0, c_r1, c_e0, c_e1; // tallies and pulse counts
  spfs_top spfs_top_i (.MCLK, .RESET, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
    .UPPER_ADDRESS_LINE, .TIMER1_PULSE, .SER0_CLK_OUT, .SER1_CLK_OUT, .DMA0_LAST_WRITE,
    .DMA1_LAST_WRITE, .PIN_ADDR_TIMER, .PIN_CK0_DREQ_IN, .PIN_CK0_DREQ_OUT, .PIN_CK0_DREQ_OE,
    .PIN_CK1_TEND_IN, .PIN_CK1_TEND_OUT, .PIN_CK1_TEND_OE, .PIN_RX_CTS, .DMA1_REQUEST_N,
    .DMA1_TRANSFER_END_N, .SER0_CLK_IN, .SER1_CLK_IN, .DMA0_REQ, .DMA1_REQ,
    .CLOCKED_SERIAL_RX, .SERIAL1_CLEAR_TO_SEND_N);
  spfs_ext_peer spfs_ext_peer_i (.ck0_oe(PIN_CK0_DREQ_OE), .ck0_out(PIN_CK0_DREQ_OUT),
    .ck1_oe(PIN_CK1_TEND_OE), .ck1_out(PIN_CK1_TEND_OUT), .ext0(ext0), .ext1(ext1),
    .req1_lvl(req1), .pin0(PIN_CK0_DREQ_IN), .pin1(PIN_CK1_TEND_IN), .req1_n(DMA1_REQUEST_N));
  // 100 MHz clock
  always #5 MCLK = ~MCLK;
  // compare and tally
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // single-bit compare
  task automatic checkb(input string what, input logic seen, input logic exp);
    check(what, {7'h00, seen}, {7'h00, exp});
  endtask
  // one-cycle register write
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge MCLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask
  // one-cycle read, data taken in the following cycle
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge MCLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask
  // load the three selection registers and let the pin flops follow
  task automatic apply();
    wr(SPFS_OFF_TIMER, t_reg);
    wr(SPFS_OFF_DMA, d_reg);
    wr(SPFS_OFF_SER1, s_reg);
    repeat (4) @(posedge MCLK);
    #1;
  endtask
  // compare every routed output with the selection worked out here
  task automatic check_all();
    logic ts, ds, es, cs;
    logic [7:0] st, rb;
    ts = t_reg[0] | t_reg[1];
    ds = d_reg[0] | d_reg[1];
    es = s_reg[0];
    cs = s_reg[1];
    checkb("pin_a", PIN_ADDR_TIMER, ts ? TIMER1_PULSE : UPPER_ADDRESS_LINE);
    checkb("ck0_oe", PIN_CK0_DREQ_OE, !ds && s_reg[2]);
    if (!ds && s_reg[2]) checkb("ck0_out", PIN_CK0_DREQ_OUT, SER0_CLK_OUT);
    if (!s_reg[2] || ds) checkb("ck0_in", SER0_CLK_IN, !ds && ext0);
    checkb("dma0_request", DMA0_REQ, ds && !d_reg[2] && !d_reg[3] && !ext0);
    checkb("ck1_oe", PIN_CK1_TEND_OE, es || s_reg[3]);
    if (es || s_reg[3]) checkb("ck1_out", PIN_CK1_TEND_OUT, es || SER1_CLK_OUT);
    if (!es && !s_reg[3]) checkb("ck1_in", SER1_CLK_IN, ext1);
    if (es) checkb("ck1_in_off", SER1_CLK_IN, 1'b0);
    checkb("rx", CLOCKED_SERIAL_RX, cs || PIN_RX_CTS);
    checkb("cts", SERIAL1_CLEAR_TO_SEND_N, !cs || PIN_RX_CTS);
    checkb("dma1_request", DMA1_REQ, !d_reg[4] && !req1);
    checkb("dma1_transfer_end", DMA1_TRANSFER_END_N, 1'b1);
    wr(SPFS_OFF_STAT, 8'hFF);
    rd(SPFS_OFF_STAT, st);
    check("status", st, {4'h0, cs, es, ds, ts});
    rd(SPFS_OFF_TIMER, rb);
    check("timer_reg", rb, t_reg);
    rd(SPFS_OFF_DMA, rb);
    check("dma_reg", rb, d_reg);
    rd(SPFS_OFF_SER1, rb);
    check("ser1_reg", rb, s_reg);
  endtask
  // reset for six cycles and expect the default functions
  task automatic do_reset();
    @(posedge MCLK);
    RESET <= 1'b1;
    repeat (6) @(posedge MCLK);
    RESET <= 1'b0;
    {t_reg, d_reg, s_reg} = {SPFS_RST_REG, SPFS_RST_REG, SPFS_RST_REG};
    repeat (2) @(posedge MCLK);
    #1 check_all();
  endtask
  // verdict and end of run
  task automatic test_done();
    if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #100000;
    fail_count++;
    test_done();
  end
  // main sequence
  initial begin
    c_r0 = $urandom(32'hF838EFBA);
    do_reset();
    for (int n = 0; n < 40; n++) begin
      @(posedge MCLK);
      {UPPER_ADDRESS_LINE, TIMER1_PULSE, SER0_CLK_OUT, SER1_CLK_OUT} <= 4'($urandom);
      {ext0, ext1, PIN_RX_CTS, req1} <= 4'($urandom);
      t_reg = 8'($urandom) & 8'h03;
      d_reg = 8'($urandom) & 8'h1F;
      s_reg = 8'($urandom) & 8'h0F;
      apply();
      check_all();
      if (n == 20) do_reset();
    end
    // edge-sensed requests and both transfer ends in one burst
    {t_reg, d_reg, s_reg} = {8'h00, 8'h19, 8'h01};
    {ext0, req1} <= 2'h3;
    apply();
    c_r0 = 0;
    c_r1 = 0;
    c_e0 = 0;
    c_e1 = 0;
    @(posedge MCLK);
    {ext0, req1, DMA0_LAST_WRITE, DMA1_LAST_WRITE} <= 4'h3;
    @(posedge MCLK);
    {DMA0_LAST_WRITE, DMA1_LAST_WRITE} <= 2'h0;
    repeat (8) begin
      @(posedge MCLK);
      #1;
      c_r0 += int'(DMA0_REQ === 1'b1);
      c_r1 += int'(DMA1_REQ === 1'b1);
      c_e0 += int'(PIN_CK1_TEND_OE === 1'b1 && PIN_CK1_TEND_OUT === 1'b0);
      c_e1 += int'(DMA1_TRANSFER_END_N === 1'b0);
    end
    check("edge_req0", 8'(c_r0), 8'h01);
    check("edge_req1", 8'(c_r1), 8'h01);
    check("end0", 8'(c_e0), 8'(SPFS_END_CYCLES));
    check("end1", 8'(c_e1), 8'(SPFS_END_CYCLES));
    test_done();
  end
endmodule // spfs_top_tb
